// *** uttr_pkg.sv ***
// Package for the unbalance stage trip timing and event recorder: types, register map, timing counts.
// Assumes one 50 MHz clock and a measurement front end on the same clock.
package uttr_pkg;
	localparam int NSTG = 4;
	localparam int NREC = 12;
	localparam int CLK_MHZ = 50;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;
	localparam int HIST_STEP_MS = 5;
	localparam int PRE_TRIG_MS = 20;
	localparam int PRE_FAULT_MS = 200;
	localparam int HIST_LEN = PRE_FAULT_MS / HIST_STEP_MS;
	localparam int PRE_TRIG_IDX = PRE_TRIG_MS / HIST_STEP_MS - 1;
	localparam logic [20:0] REM_MAX_MS = 21'd1800000;
	localparam logic [31:0] RESET_PCT = 32'd97;
	localparam logic [31:0] PCT_FULL = 32'd100;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_IRQ_ST = 8'h04;
	localparam logic [7:0] REG_IRQ_MASK = 8'h08;
	localparam logic [7:0] REG_TIME = 8'h0C;
	localparam logic [7:0] REG_REC_SEL = 8'h10;
	localparam logic [7:0] REG_REC_INFO = 8'h14;
	localparam logic [3:0] STG_PAGE = 4'h2;
	localparam logic [3:0] CNT_PAGE = 4'h6;
	localparam logic [3:0] REC_PAGE = 4'hA;
	localparam logic [3:0] STG_CFG = 4'h0;
	localparam logic [3:0] STG_PICK = 4'h4;
	localparam logic [3:0] STG_K = 4'h8;
	localparam logic [3:0] STG_STAT = 4'hC;
	localparam int CTRL_CLR_BIT = 0;
	localparam int CTRL_GRP_LSB = 4;
	// Reset values
	localparam logic [15:0] PICK_RST = 16'h00C8;
	localparam logic [31:0] K_RST = 32'h0000_03E8;
	typedef enum logic [1:0] {MODE_INSTANT = 2'b00, MODE_FIXED = 2'b01, MODE_INVERSE = 2'b10,
		MODE_SQUARED = 2'b11} uttr_mode_e;
	typedef enum logic [1:0] {CURVE_IEC = 2'b00, CURVE_IEEE = 2'b01, CURVE_USER = 2'b10,
		CURVE_RSVD = 2'b11} uttr_curve_e;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_START = 2'b01, ST_TRIP = 2'b10, ST_BLK = 2'b11} uttr_stage_e;
	typedef enum logic [1:0] {KIND_START = 2'b00, KIND_TRIP = 2'b01, KIND_BLK = 2'b10} uttr_kind_e;
	typedef struct packed {
		logic [5:0] evt_sel;
		logic [7:0] user_a;
		logic [2:0] rsvd;
		logic rel_hold;
		uttr_curve_e curve;
		uttr_mode_e mode;
	} uttr_cfg_s;
	localparam uttr_cfg_s CFG_RST = '{evt_sel: 6'h3F, user_a: 8'h01, rsvd: 3'h0, rel_hold: 1'b0,
		curve: CURVE_IEC, mode: MODE_FIXED};
	typedef struct packed {
		logic [15:0] i1;
		logic [15:0] i2;
		logic [15:0] iz;
		logic [15:0] a1;
		logic [15:0] a2;
		logic [15:0] az;
	} uttr_meas_s;
	typedef struct packed {
		logic valid;
		logic [1:0] stage;
		uttr_kind_e kind;
		logic on;
		logic [31:0] ts;
	} uttr_evt_s;
	typedef struct packed {
		logic [1:0] stage;
		uttr_kind_e kind;
		logic [2:0] group;
		logic [31:0] ts;
		logic [15:0] pre_trig;
		logic [15:0] fault;
		logic [15:0] pre_fault;
		uttr_meas_s seq;
		logic [20:0] rem;
	} uttr_rec_s;
endpackage

// *** uttr_recorder.sv ***
// Four unbalance stages with trip timing, event stream, counters, fault record ring and register port.
// Assumes measurements and blocking come from logic on i_clk; registers reached by a plain strobe port.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module uttr_recorder #(
	parameter int TICK_CYCLES = uttr_pkg::TICK_CYC
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire uttr_pkg::uttr_meas_s i_meas,
	input wire logic [3:0] i_block,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic [3:0] o_start,
	output logic [3:0] o_trip,
	output logic [3:0] o_blocked,
	output uttr_pkg::uttr_evt_s o_evt,
	output logic o_irq
);
	import uttr_pkg::*;

	if (TICK_CYCLES < 2) begin : g_chk
		$error("TICK_CYCLES must be at least 2");
	end

	// History must hold the pre-trigger sample, and the 3-bit step counter must reach the step
	if (HIST_LEN < 2 || PRE_TRIG_IDX < 0 || PRE_TRIG_IDX >= HIST_LEN || HIST_STEP_MS > 8) begin : g_chk_hist
		$error("history window cannot hold the pre-trigger sample");
	end

	typedef struct packed {
		uttr_stage_e st;
		logic pu;
		logic [39:0] acc;
		logic [20:0] rem;
		logic [15:0] pre_fault;
		uttr_cfg_s cfg;
		logic [15:0] pick;
		logic [31:0] k;
	} uttr_stg_s;

	localparam uttr_stg_s STG_RST = '{st: ST_IDLE, pu: 1'b0, acc: 40'h0, rem: 21'h0, pre_fault: 16'h0,
		cfg: CFG_RST, pick: PICK_RST, k: K_RST};

	typedef struct packed {
		logic [31:0] tick_cnt;
		logic [31:0] ms;
		logic [2:0] hcnt;
		logic [HIST_LEN-1:0][15:0] hist;
		uttr_stg_s [NSTG-1:0] stg;
		logic [23:0] evt_pend;
		logic [11:0] rec_pend;
		uttr_rec_s [NREC-1:0] recs;
		logic [3:0] head;
		logic [3:0] count;
		logic [NSTG-1:0][2:0][15:0] cnt;
		logic [11:0] irq_st;
		logic [11:0] irq_mask;
		logic [2:0] group;
		logic [3:0] rec_sel;
		logic [31:0] rdata;
		uttr_evt_s evt;
		logic irq;
		logic [3:0] start;
		logic [3:0] trip;
		logic [3:0] blocked;
	} uttr_state_s;

	uttr_state_s st;
	uttr_state_s next_st;

	always_comb begin
		logic tick;
		logic hi;
		logic lo;
		logic up;
		logic blk;
		logic found;
		logic cnt_clr;
		logic [1:0] sidx;
		logic [2:0] old_f;
		logic [2:0] new_f;
		logic [15:0] exc;
		logic [31:0] sq;
		logic [31:0] ps;
		logic [31:0] rate;
		logic [39:0] acc_n;
		logic [39:0] q;
		uttr_rec_s rec;
		tick = 1'b0;
		hi = 1'b0;
		lo = 1'b0;
		up = 1'b0;
		blk = 1'b0;
		found = 1'b0;
		cnt_clr = 1'b0;
		sidx = 2'h0;
		old_f = 3'h0;
		new_f = 3'h0;
		exc = 16'h0;
		sq = 32'h0;
		ps = 32'h0;
		rate = 32'h0;
		acc_n = 40'h0;
		q = 40'h0;
		rec = '0;
		next_st = st;
		next_st.evt = '0;
		next_st.rdata = 32'h0;

		// Millisecond evaluation tick and 5 ms current history
		tick = (st.tick_cnt == 32'(TICK_CYCLES - 1));
		next_st.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;
		if (tick) begin
			next_st.ms = st.ms + 32'h1;
			next_st.hcnt = (st.hcnt == 3'(HIST_STEP_MS - 1)) ? 3'h0 : st.hcnt + 3'h1;
			if (st.hcnt == 3'(HIST_STEP_MS - 1)) begin
				next_st.hist = {st.hist[HIST_LEN-2:0], i_meas.i2};
			end
		end

		// Register writes
		if (i_wr) begin
			if (i_addr == REG_CTRL) begin
				cnt_clr = i_wdata[CTRL_CLR_BIT];
				next_st.group = i_wdata[CTRL_GRP_LSB +: 3];
			end else if (i_addr == REG_IRQ_ST) begin
				next_st.irq_st = st.irq_st & ~i_wdata[11:0];
			end else if (i_addr == REG_IRQ_MASK) begin
				next_st.irq_mask = i_wdata[11:0];
			end else if (i_addr == REG_REC_SEL) begin
				next_st.rec_sel = (i_wdata[3:0] < 4'(NREC)) ? i_wdata[3:0] : st.rec_sel;
			end else if (i_addr[7:4] >= STG_PAGE && i_addr[7:4] < CNT_PAGE) begin
				sidx = 2'(i_addr[7:4] - STG_PAGE);
				unique case (i_addr[3:0])
					STG_CFG: next_st.stg[sidx].cfg = uttr_cfg_s'(i_wdata);
					STG_PICK: next_st.stg[sidx].pick = i_wdata[15:0];
					STG_K: next_st.stg[sidx].k = i_wdata;
					default: ;
				endcase
			end
		end
		if (cnt_clr) begin
			next_st.cnt = '0;
		end

		for (int s = 0; s < NSTG; s++) begin
			if (tick) begin
				// Hysteresis: compare scaled values to avoid a divider
				hi = i_meas.i2 >= st.stg[s].pick;
				lo = ({16'h0, i_meas.i2} * PCT_FULL) < ({16'h0, st.stg[s].pick} * RESET_PCT);
				up = hi | (st.stg[s].pu & ~lo);
				blk = i_block[s];
				next_st.stg[s].pu = up;
				exc = hi ? i_meas.i2 - st.stg[s].pick : 16'h0;
				sq = {16'h0, i_meas.i2} * {16'h0, i_meas.i2};
				ps = {16'h0, st.stg[s].pick} * {16'h0, st.stg[s].pick};
				unique case (st.stg[s].cfg.mode)
					MODE_INSTANT: rate = 32'h0;
					MODE_FIXED: rate = 32'h1;
					MODE_SQUARED: rate = hi ? sq - ps : 32'h0;
					MODE_INVERSE: begin
						// Progress per tick grows with overcurrent, so delay shrinks
						unique case (st.stg[s].cfg.curve)
							CURVE_IEC: rate = {16'h0, exc};
							CURVE_IEEE: rate = hi ? sq - ps : 32'h0;
							default: rate = {16'h0, exc} * {24'h0, st.stg[s].cfg.user_a};
						endcase
					end
				endcase
				acc_n = st.stg[s].acc + {8'h0, rate};
				unique case (st.stg[s].st)
					ST_IDLE: begin
						if (up && blk) begin
							next_st.stg[s].st = ST_BLK;
						end else if (up && st.stg[s].cfg.mode == MODE_INSTANT) begin
							next_st.stg[s].st = ST_TRIP;
							next_st.stg[s].pre_fault = st.hist[HIST_LEN-1];
						end else if (up) begin
							next_st.stg[s].st = ST_START;
							next_st.stg[s].pre_fault = st.hist[HIST_LEN-1];
							next_st.stg[s].acc = st.stg[s].cfg.rel_hold ? st.stg[s].acc : 40'h0;
						end
					end
					ST_START: begin
						if (!up || blk) begin
							next_st.stg[s].st = (up && blk) ? ST_BLK : ST_IDLE;
							next_st.stg[s].acc = st.stg[s].cfg.rel_hold ? st.stg[s].acc : 40'h0;
						end else if (acc_n >= {8'h0, st.stg[s].k}) begin
							next_st.stg[s].st = ST_TRIP;
							next_st.stg[s].acc = 40'h0;
						end else begin
							next_st.stg[s].acc = acc_n;
						end
					end
					ST_TRIP: begin
						if (!up || blk) begin
							next_st.stg[s].st = (up && blk) ? ST_BLK : ST_IDLE;
							next_st.stg[s].acc = 40'h0;
						end
					end
					ST_BLK: begin
						if (!up || !blk) begin
							next_st.stg[s].st = ST_IDLE;
						end
					end
				endcase
				// Remaining time; a divider per stage is the cost of a live figure
				if (next_st.stg[s].st != ST_START) begin
					next_st.stg[s].rem = 21'h0;
				end else if (rate == 32'h0) begin
					next_st.stg[s].rem = REM_MAX_MS;
				end else begin
					q = ({8'h0, st.stg[s].k} - next_st.stg[s].acc) / {8'h0, rate};
					next_st.stg[s].rem = (q > {19'h0, REM_MAX_MS}) ? REM_MAX_MS : q[20:0];
				end
			end
			next_st.start[s] = next_st.stg[s].st == ST_START || next_st.stg[s].st == ST_TRIP;
			next_st.trip[s] = next_st.stg[s].st == ST_TRIP;
			next_st.blocked[s] = next_st.stg[s].st == ST_BLK;
		end

		// Event emission: one pending event and one record per cycle, lowest index first
		found = 1'b0;
		for (int p = 0; p < 24; p++) begin
			if (!found && st.evt_pend[p]) begin
				found = 1'b1;
				next_st.evt_pend[p] = 1'b0;
				next_st.evt.valid = 1'b1;
				next_st.evt.stage = 2'(p / 6);
				next_st.evt.kind = uttr_kind_e'(2'((p % 6) / 2));
				next_st.evt.on = (p % 2) == 0;
				next_st.evt.ts = st.ms;
			end
		end
		found = 1'b0;
		for (int p = 0; p < 12; p++) begin
			if (!found && st.rec_pend[p]) begin
				found = 1'b1;
				next_st.rec_pend[p] = 1'b0;
				sidx = 2'(p / 3);
				rec.stage = sidx;
				rec.kind = uttr_kind_e'(2'(p % 3));
				rec.group = st.group;
				rec.ts = st.ms;
				rec.pre_trig = st.hist[PRE_TRIG_IDX];
				rec.fault = i_meas.i2;
				rec.pre_fault = st.stg[sidx].pre_fault;
				rec.seq = i_meas;
				rec.rem = st.stg[sidx].rem;
				next_st.recs[st.head] = rec;
				next_st.head = (st.head == 4'(NREC - 1)) ? 4'h0 : st.head + 4'h1;
				next_st.count = (st.count == 4'(NREC)) ? st.count : st.count + 4'h1;
			end
		end

		// Edge detection; new sets are applied last so they beat clears in the same cycle
		for (int s = 0; s < NSTG; s++) begin
			old_f = {st.blocked[s], st.trip[s], st.start[s]};
			new_f = {next_st.blocked[s], next_st.trip[s], next_st.start[s]};
			for (int k = 0; k < 3; k++) begin
				if (new_f[k] && !old_f[k]) begin
					next_st.cnt[s][k] = next_st.cnt[s][k] + 16'h1;
					next_st.rec_pend[s * 3 + k] = 1'b1;
					next_st.irq_st[s * 3 + k] = 1'b1;
					if (st.stg[s].cfg.evt_sel[k * 2]) begin
						next_st.evt_pend[s * 6 + k * 2] = 1'b1;
					end
				end
				if (!new_f[k] && old_f[k] && st.stg[s].cfg.evt_sel[k * 2 + 1]) begin
					next_st.evt_pend[s * 6 + k * 2 + 1] = 1'b1;
				end
			end
		end
		next_st.irq = |(next_st.irq_st & next_st.irq_mask);

		// Register reads, data in the following cycle only
		if (i_rd) begin
			sidx = 2'(i_addr[5:4] - 2'h2);
			if (i_addr == REG_CTRL) begin
				next_st.rdata = {25'h0, st.group, 4'h0};
			end else if (i_addr == REG_IRQ_ST) begin
				next_st.rdata = {20'h0, st.irq_st};
			end else if (i_addr == REG_IRQ_MASK) begin
				next_st.rdata = {20'h0, st.irq_mask};
			end else if (i_addr == REG_TIME) begin
				next_st.rdata = st.ms;
			end else if (i_addr == REG_REC_SEL) begin
				next_st.rdata = {28'h0, st.rec_sel};
			end else if (i_addr == REG_REC_INFO) begin
				next_st.rdata = {20'h0, st.count, 4'h0, st.head};
			end else if (i_addr[7:4] >= STG_PAGE && i_addr[7:4] < CNT_PAGE) begin
				sidx = 2'(i_addr[7:4] - STG_PAGE);
				unique case (i_addr[3:0])
					STG_CFG: next_st.rdata = 32'(st.stg[sidx].cfg);
					STG_PICK: next_st.rdata = {16'h0, st.stg[sidx].pick};
					STG_K: next_st.rdata = st.stg[sidx].k;
					STG_STAT: next_st.rdata = {3'h0, st.stg[sidx].rem, 5'h0, st.stg[sidx].pu, st.stg[sidx].st};
					default: next_st.rdata = 32'h0;
				endcase
			end else if (i_addr[7:4] >= CNT_PAGE && i_addr[7:4] < REC_PAGE) begin
				sidx = 2'(i_addr[7:4] - CNT_PAGE);
				next_st.rdata = (i_addr[3:2] == 2'h3) ? 32'h0 : {16'h0, st.cnt[sidx][i_addr[3:2]]};
			end else if (i_addr[7:5] == REC_PAGE[3:1]) begin
				rec = st.recs[st.rec_sel];
				unique case (i_addr[4:2])
					3'h0: next_st.rdata = {25'h0, rec.group, rec.stage, rec.kind};
					3'h1: next_st.rdata = rec.ts;
					3'h2: next_st.rdata = {rec.pre_trig, rec.fault};
					3'h3: next_st.rdata = {rec.pre_fault, rec.seq.i1};
					3'h4: next_st.rdata = {rec.seq.i2, rec.seq.iz};
					3'h5: next_st.rdata = {rec.seq.a1, rec.seq.a2};
					3'h6: next_st.rdata = {rec.seq.az, 16'h0};
					3'h7: next_st.rdata = {11'h0, rec.rem};
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st <= '0;
			for (int s = 0; s < NSTG; s++) begin
				st.stg[s] <= STG_RST;
			end
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_start = st.start;
	assign o_trip = st.trip;
	assign o_blocked = st.blocked;
	assign o_evt = st.evt;
	assign o_irq = st.irq;
endmodule
`default_nettype wire

// *** uttr_properties.sv ***
// Port checker for the unbalance stage recorder.
// Assumes a tick period above eight cycles and blocking held across ticks.
`timescale 1ns/10ps
`default_nettype none
module uttr_properties (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [3:0] i_block,
	input wire logic [3:0] o_start,
	input wire logic [3:0] o_trip,
	input wire logic [3:0] o_blocked,
	input wire uttr_pkg::uttr_evt_s o_evt
);
	import uttr_pkg::*;
	logic [5:0] since;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// Cycles since the last output change, saturating
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) since <= 6'h3F;
		else if ($changed({o_start, o_trip, o_blocked})) since <= 6'h00;
		else if (since != 6'h3F) since <= since + 6'h01;
	end
	AST_TRIP_WITH_START: assert property ((o_trip & ~o_start) == 4'h0)
		else $error("trip without start");
	AST_BLK_NOT_START: assert property ((o_blocked & o_start) == 4'h0)
		else $error("blocked together with start");
	AST_BLK_NEEDS_BLOCK: assert property ((o_blocked & ~$past(o_blocked) & ~$past(i_block)) == 4'h0)
		else $error("blocked rose without blocking");
	AST_START_NOT_BLOCKED: assert property ((o_start & ~$past(o_start) & $past(i_block)) == 4'h0)
		else $error("start rose while blocked");
	AST_OUT_HOLD: assert property ($changed({o_start, o_trip, o_blocked}) |=> $stable({o_start, o_trip, o_blocked})[*8])
		else $error("outputs changed between ticks");
	AST_TRIP_DROP_BLOCK: assert property (o_trip[0] && i_block[0] |-> ##[1:25] !o_trip[0])
		else $error("trip kept under blocking");
	AST_START_EVENT: assert property ($rose(o_start[0]) |=> o_evt.valid && o_evt.stage == 2'h0 && o_evt.kind == KIND_START && o_evt.on)
		else $error("no start event after start");
	AST_EVT_KIND: assert property (o_evt.valid |-> o_evt.kind != 2'h3)
		else $error("event with unknown kind");
	AST_EVT_FROM_EDGE: assert property (o_evt.valid |-> since < 6'h1A)
		else $error("event without output change");
endmodule
`default_nettype wire

// *** uttr_front.sv ***
// Measurement front end and blocking matrix stand-in.
// Assumes the bench sets levels; outputs are registered on i_clk.
`timescale 1ns/10ps
`default_nettype none
module uttr_front (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [15:0] i_neg,
	input wire logic [15:0] i_noise,
	input wire logic [3:0] i_blk,
	output uttr_pkg::uttr_meas_s o_meas,
	output logic [3:0] o_block
);
	import uttr_pkg::*;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_meas <= '0;
			o_block <= 4'h0;
		end else begin
			// Side values wander every cycle so stale samples never look settled
			o_meas <= '{i1: i_noise, i2: i_neg, iz: ~i_noise, a1: i_noise ^ 16'h5A5A,
				a2: {i_noise[7:0], i_noise[15:8]}, az: i_noise + 16'h0101};
			o_block <= i_blk;
		end
	end
endmodule
`default_nettype wire

// *** test_uttr_recorder.sv ***
// Self-checking bench for the unbalance stage recorder with a short tick.
// Assumes the package register map and the front end model.
`timescale 1ns/10ps
`default_nettype none
module test_uttr_recorder;
	import uttr_pkg::*;
	localparam int TK = 20;
	logic i_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] neg = 16'h0;
	logic [15:0] noise = 16'h0;
	logic [3:0] blk = 4'h0;
	uttr_meas_s meas;
	logic [3:0] block, o_start, o_trip, o_blocked;
	logic [31:0] o_rdata;
	uttr_evt_s o_evt;
	logic o_irq;
	logic rd_pend = 1'b0;
	int fail_count = 0;
	int checks_done = 0;
	int seed = 71;
	int cyc = 0;
	logic [31:0] rd_q[$];
	logic [4:0] evt_q[$];
	uttr_front front (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_neg(neg), .i_noise(noise), .i_blk(blk),
		.o_meas(meas), .o_block(block));
	uttr_recorder #(.TICK_CYCLES(TK)) uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_meas(meas), .i_block(block),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_start(o_start),
		.o_trip(o_trip), .o_blocked(o_blocked), .o_evt(o_evt), .o_irq(o_irq));
	initial forever #10 i_clk = ~i_clk;
	always @(posedge i_clk) noise <= 16'($random(seed));
	// Edges since reset release; the millisecond stamp is the tick count one edge back
	always @(posedge i_clk) if (i_arst_n) cyc <= cyc + 1;
	task automatic bad(input string msg);
		fail_count++;
		$display("MISMATCH at %0t: %s", $time, msg);
	endtask
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) bad($sformatf("got %h, expected %h", got, exp));
	endtask
	task automatic cmp_rd();
		if (rd_q.size() == 0) bad("read data without note");
		else cmp_val(o_rdata, rd_q.pop_front());
	endtask
	task automatic cmp_evt();
		if (evt_q.size() == 0) bad("event without note");
		else begin
			cmp_val({27'h0, o_evt.stage, o_evt.kind, o_evt.on}, {27'h0, evt_q.pop_front()});
			cmp_val(o_evt.ts, 32'((cyc - 1) / TK));
		end
	endtask
	// Sampled mid-cycle so read data and event pulses have settled
	always @(negedge i_clk) begin
		if (rd_pend) cmp_rd();
		if (o_evt.valid === 1'b1) cmp_evt();
		rd_pend = i_rd;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		rd_q.push_back(e);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask
	task automatic tk(input int n);
		repeat (n * TK) @(posedge i_clk);
	endtask
	task automatic drive(input logic [15:0] v, input logic [3:0] b);
		@(posedge i_clk);
		neg <= v;
		blk <= b;
	endtask
	task automatic ev(input int s, input int k, input int o);
		evt_q.push_back({2'(s), 2'(k), 1'(o)});
	endtask
	task automatic wait_hi(input logic trip, output int n);
		n = 0;
		while ((trip ? o_trip[0] : o_start[0]) !== 1'b1 && n < 200) begin
			@(posedge i_clk);
			#1;
			n++;
		end
	endtask
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clk);
		bad("watchdog expired");
		give_verdict();
	end
	initial begin
		int n;
		repeat (4) @(posedge i_clk);
		i_arst_n <= 1'b1;
		rd(8'h20, 32'h003F_0101);
		rd(8'h24, 32'h0000_00C8);
		rd(8'h28, 32'h0000_03E8);
		rd(8'hFC, 32'h0);
		for (int s = 1; s < 4; s++) wr(8'h24 + 8'(s * 16), 32'h0000_FFFF);
		wr(8'h28, 32'h2);
		wr(8'h00, 32'h30);
		wr(8'h08, 32'h1);
		rd(8'h00, 32'h30);
		ev(0, 0, 1);
		ev(0, 1, 1);
		drive(16'h0100, 4'h0);
		wait_hi(1'b0, n);
		wait_hi(1'b1, n);
		cmp_val(n, 2 * TK);
		cmp_val(o_irq, 1'b1);
		drive(16'h00C2, 4'h0);
		tk(3);
		cmp_val(o_trip[0], 1'b1);
		ev(0, 0, 0);
		ev(0, 1, 0);
		drive(16'h00C1, 4'h0);
		tk(2);
		cmp_val(o_start[0], 1'b0);
		rd(8'h60, 32'h1);
		rd(8'h64, 32'h1);
		rd(8'h14, 32'h0000_0202);
		wr(8'h10, 32'h1);
		rd(8'hA0, 32'h31);
		rd(8'h04, 32'h3);
		wr(8'h04, 32'h3);
		wr(8'h00, 32'h31);
		rd(8'h04, 32'h0);
		rd(8'h60, 32'h0);
		cmp_val(o_irq, 1'b0);
		wr(8'h20, 32'h003F_0100);
		ev(0, 0, 1);
		ev(0, 1, 1);
		drive(16'h0100, 4'h0);
		wait_hi(1'b0, n);
		cmp_val(o_trip[0], 1'b1);
		tk(2);
		ev(0, 0, 0);
		ev(0, 1, 0);
		ev(0, 2, 1);
		drive(16'h0100, 4'h1);
		tk(2);
		ev(0, 2, 0);
		drive(16'h0, 4'h0);
		tk(2);
		ev(0, 2, 1);
		drive(16'h0100, 4'h1);
		tk(2);
		cmp_val({o_start[0], o_blocked[0]}, 2'b01);
		ev(0, 2, 0);
		drive(16'h0, 4'h0);
		tk(2);
		wr(8'h20, 32'h0001_0100);
		ev(0, 0, 1);
		drive(16'h0100, 4'h0);
		tk(2);
		drive(16'h0, 4'h0);
		tk(2);
		wr(8'h40, 32'h003F_0100);
		wr(8'h44, 32'h0300);
		ev(0, 0, 1);
		ev(2, 0, 1);
		ev(2, 1, 1);
		drive(16'h0310, 4'h0);
		tk(2);
		cmp_val({o_start, o_trip}, 8'h55);
		rd(8'h4C, 32'h0000_0006);
		rd(8'h14, 32'h0000_0C00);
		wr(8'h10, 32'hB);
		rd(8'hA0, 32'h39);
		rd(8'h60, 32'h3);
		rd(8'h68, 32'h2);
		rd(8'h80, 32'h1);
		ev(2, 0, 0);
		ev(2, 1, 0);
		drive(16'h0, 4'h0);
		tk(2);
		wr(8'h20, 32'h0001_0003);
		wr(8'h28, 32'h0000_2640);
		ev(0, 0, 1);
		drive(16'h00D0, 4'h0);
		wait_hi(1'b0, n);
		wait_hi(1'b1, n);
		cmp_val(n, 3 * TK);
		drive(16'h0, 4'h0);
		tk(2);
		wr(8'h20, 32'h0001_0002);
		wr(8'h28, 32'h0000_0018);
		ev(0, 0, 1);
		drive(16'h00D0, 4'h0);
		wait_hi(1'b0, n);
		wait_hi(1'b1, n);
		cmp_val(n, 3 * TK);
		drive(16'h0, 4'h0);
		tk(2);
		wr(8'h20, 32'h0001_0011);
		wr(8'h28, 32'h0000_0004);
		ev(0, 0, 1);
		ev(0, 0, 1);
		drive(16'h00D0, 4'h0);
		wait_hi(1'b0, n);
		tk(1);
		drive(16'h0, 4'h0);
		tk(2);
		drive(16'h00D0, 4'h0);
		wait_hi(1'b0, n);
		wait_hi(1'b1, n);
		cmp_val(n, 3 * TK);
		drive(16'h0, 4'h0);
		tk(2);
		cmp_val(evt_q.size(), 0);
		give_verdict();
	end
endmodule
bind uttr_recorder uttr_properties chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_block(i_block), .o_start(o_start),
	.o_trip(o_trip), .o_blocked(o_blocked), .o_evt(o_evt));
`default_nettype wire
